// ===== core/emx_core.sv
// emx_core.sv: external data memory map, page/config registers, bus cycle sequencer
// assumes: cpu pulses one request at a time and waits for o_done; registers on sfr port
`include "emx_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module emx_core
  import emx_pkg::*;
#(
  parameter logic IRAM_4K = 1'b1
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire emx_req_s   i_req,
  input  wire logic [7:0] i_ad_pin,
  output logic [7:0]      o_sfr_rdata,
  output logic            o_done,
  output logic [7:0]      o_rdata,
  output logic            o_sel_onchip,
  output logic            o_sel_fifo,
  output logic [15:0]     o_eff_addr,
  output emx_pins_s       o_pins,
  output logic            o_latch_strobe,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_bus_claim
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALE_HI,
    ST_ALE_LO,
    ST_STROBE,
    ST_DONE
  } emx_st_e;

  logic [7:0]  cfg_r;
  logic [7:0]  page_r;
  emx_st_e     st_r;
  logic [2:0]  cnt_r;
  logic        wr_r;
  logic        hi_drive_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r;
  logic [7:0]  ad_s1_r;
  logic [7:0]  ad_s2_r;
  logic [7:0]  ad_s3_r;
  logic [7:0]  ad_ok_r;
  logic        ad_agree;
  logic [7:0]  ad_settled;

  logic        fae;
  logic        mux_sep;
  emx_map_e    map_mode;
  logic [2:0]  ale_cyc;
  logic [15:0] eff;
  logic        hit_fifo;
  logic        onchip;
  logic [15:0] iram_mask;

  function automatic logic below_boundary(input logic [15:0] a, input logic [15:0] m);
    below_boundary = (a & ~m) == 16'h0000;
  endfunction

  assign fae       = cfg_r[`EMX_CFG_FAE_BIT];
  assign mux_sep   = cfg_r[`EMX_CFG_MUX_BIT];
  assign map_mode  = emx_map_e'(cfg_r[`EMX_CFG_MAP_LSB +: 2]);
  assign ale_cyc   = {1'b0, cfg_r[`EMX_CFG_ALE_LSB +: 2]} + 3'h1;
  assign iram_mask = IRAM_4K ? `EMX_IRAM_4K_MASK : `EMX_IRAM_2K_MASK;
  assign eff       = i_req.wide ? i_req.ptr : {page_r, i_req.idx};

  // fifo window wins over any ram at the same addresses
  assign hit_fifo = fae && eff >= `EMX_FIFO_LO && eff <= `EMX_FIFO_HI;

  always_comb begin
    case (map_mode)
      EMX_MAP_INT:   onchip = 1'b1;
      EMX_MAP_SPLIT: onchip = below_boundary(eff, iram_mask);
      EMX_MAP_BANK:  onchip = below_boundary(eff, iram_mask);
      EMX_MAP_EXT:   onchip = 1'b0;
      default:       onchip = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_r  <= `EMX_CFG_RESET;
      page_r <= `EMX_PAGE_RESET;
    end else if (i_ce && i_sfr_wr) begin
      if (i_sfr_addr == `EMX_CFG_ADDR) begin
        cfg_r <= i_sfr_wdata & `EMX_CFG_WMASK;
      end
      if (i_sfr_addr == `EMX_PAGE_ADDR) begin
        page_r <= i_sfr_wdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_sfr_rd && i_sfr_addr == `EMX_CFG_ADDR) begin
        o_sfr_rdata <= cfg_r;
      end else if (i_sfr_rd && i_sfr_addr == `EMX_PAGE_ADDR) begin
        o_sfr_rdata <= page_r;
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

  // shared pins arrive asynchronously; accept a value once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ad_s1_r <= 8'h00;
      ad_s2_r <= 8'h00;
      ad_s3_r <= 8'h00;
    end else if (i_ce) begin
      ad_s1_r <= i_ad_pin;
      ad_s2_r <= ad_s1_r;
      ad_s3_r <= ad_s2_r;
    end
  end

  // a pin value only counts once the last two sampler stages agree; otherwise keep the last one
  assign ad_agree   = ad_s2_r == ad_s3_r;
  assign ad_settled = ad_agree ? ad_s3_r : ad_ok_r;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ad_ok_r <= 8'h00;
    end else if (i_ce && ad_agree) begin
      ad_ok_r <= ad_s3_r;
    end
  end

  // request decode, published ahead of the done pulse's cycle, kept simple: one cycle after start
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_r       <= 16'h0000;
      wdata_r      <= 8'h00;
      wr_r         <= 1'b0;
      hi_drive_r   <= 1'b0;
      o_sel_onchip <= 1'b0;
      o_sel_fifo   <= 1'b0;
      o_eff_addr   <= 16'h0000;
    end else if (i_ce && i_req.start && st_r == ST_IDLE) begin
      wr_r         <= i_req.wr;
      wdata_r      <= i_req.wdata;
      addr_r       <= eff;
      // an off-chip byte move in modes 01 and 11 leaves the high lines to the port latches
      hi_drive_r   <= i_req.wide || map_mode == EMX_MAP_BANK;
      o_sel_fifo   <= hit_fifo;
      o_sel_onchip <= !hit_fifo && onchip;
      o_eff_addr   <= (map_mode == EMX_MAP_INT) ? (eff & iram_mask) : eff;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r  <= ST_IDLE;
      cnt_r <= 3'h0;
    end else if (i_ce) begin
      case (st_r)
        ST_IDLE: begin
          if (i_req.start) begin
            if (hit_fifo || onchip) begin
              st_r <= ST_DONE;
            end else if (mux_sep) begin
              st_r  <= ST_STROBE;
              cnt_r <= `EMX_RD_WR_CYC;
            end else begin
              st_r  <= ST_ALE_HI;
              cnt_r <= ale_cyc;
            end
          end
        end
        ST_ALE_HI: begin
          if (cnt_r == 3'h1) begin
            st_r  <= ST_ALE_LO;
            cnt_r <= ale_cyc;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ST_ALE_LO: begin
          if (cnt_r == 3'h1) begin
            st_r  <= ST_STROBE;
            cnt_r <= `EMX_RD_WR_CYC;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ST_STROBE: begin
          if (cnt_r == 3'h1) begin
            st_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        ST_DONE: begin
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_latch_strobe <= 1'b0;
      o_rd_n         <= 1'b1;
      o_wr_n         <= 1'b1;
      o_bus_claim    <= 1'b0;
      o_done         <= 1'b0;
      o_rdata        <= 8'h00;
      o_pins         <= '0;
    end else if (i_ce) begin
      o_done <= (st_r == ST_DONE);
      case (st_r)
        ST_ALE_HI: begin
          o_bus_claim    <= 1'b1;
          o_latch_strobe <= 1'b1;
          o_pins.ad_o    <= addr_r[7:0];
          o_pins.ad_oe   <= 8'hFF;
          o_pins.ahi_o   <= addr_r[15:8];
          o_pins.ahi_oe  <= hi_drive_r ? 8'hFF : 8'h00;
          o_pins.alo_oe  <= 8'h00;
        end
        ST_ALE_LO: begin
          o_latch_strobe <= 1'b0;
          o_pins.ad_o    <= wdata_r;
          o_pins.ad_oe   <= wr_r ? 8'hFF : 8'h00;
        end
        ST_STROBE: begin
          o_bus_claim    <= 1'b1;
          o_latch_strobe <= 1'b0;
          o_rd_n         <= wr_r;
          o_wr_n         <= !wr_r;
          o_pins.ad_o    <= wdata_r;
          o_pins.ad_oe   <= wr_r ? 8'hFF : 8'h00;
          o_pins.ahi_o   <= addr_r[15:8];
          o_pins.ahi_oe  <= hi_drive_r ? 8'hFF : 8'h00;
          o_pins.alo_o   <= addr_r[7:0];
          o_pins.alo_oe  <= mux_sep ? 8'hFF : 8'h00;
        end
        default: begin
          if (o_rd_n == 1'b0) begin
            o_rdata <= ad_settled;
          end
          o_bus_claim    <= 1'b0;
          o_latch_strobe <= 1'b0;
          o_rd_n         <= 1'b1;
          o_wr_n         <= 1'b1;
          o_pins         <= '0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== dv/emx_core_chk.sv
// emx_core_chk.sv: port-level assertions for emx_core
// assumes: bound into emx_core, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module emx_core_chk
  import emx_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_ce,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        o_sel_onchip,
  input wire logic        o_sel_fifo,
  input wire logic [15:0] o_eff_addr,
  input wire emx_pins_s   o_pins,
  input wire logic        o_latch_strobe,
  input wire logic        o_rd_n,
  input wire logic        o_wr_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic [1:0] alw_r;
  logic       mux_r;
  logic [2:0] cnt_r;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      alw_r <= 2'h3;
      mux_r <= 1'b0;
    end else if (i_ce && i_sfr_wr && i_sfr_addr == 8'h85) begin
      alw_r <= i_sfr_wdata[1:0];
      mux_r <= i_sfr_wdata[4];
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) cnt_r <= 3'h0;
    else cnt_r <= o_latch_strobe ? cnt_r + 3'h1 : 3'h0;
  end
  cfg_mask_a: assert property (i_ce && i_sfr_rd && i_sfr_addr == 8'h85 |=>
    !o_sfr_rdata[7] && !o_sfr_rdata[5]) else $error("config spare bits not zero");
  ale_addr_a: assert property (o_latch_strobe |-> o_pins.ad_oe == 8'hFF &&
    o_pins.ad_o == o_eff_addr[7:0]) else $error("low address missing in strobe phase");
  ale_width_a: assert property ($fell(o_latch_strobe) |->
    cnt_r == {1'b0, alw_r} + 3'h1) else $error("latch strobe width wrong");
  nomux_ale_a: assert property (mux_r |-> !o_latch_strobe)
    else $error("latch strobe in separate pin mode");
  rd_release_a: assert property ($fell(o_rd_n) |-> o_pins.ad_oe == 8'h00 &&
    !o_latch_strobe) else $error("data pins driven at read");
  wr_drive_a: assert property (!o_wr_n |-> o_pins.ad_oe == 8'hFF)
    else $error("data pins not driven at write");
  onchip_quiet_a: assert property (o_sel_onchip |-> o_rd_n && o_wr_n &&
    !o_latch_strobe) else $error("bus cycle on on-chip access");
  fifo_range_a: assert property (o_sel_fifo |-> o_eff_addr >= 16'h0400 &&
    o_eff_addr <= 16'h07FF) else $error("fifo selected outside window");
endmodule
bind emx_core emx_core_chk u_chk (.i_clk_sys, .i_rstn, .i_ce, .i_sfr_wr, .i_sfr_rd,
  .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .o_sel_onchip, .o_sel_fifo, .o_eff_addr,
  .o_pins, .o_latch_strobe, .o_rd_n, .o_wr_n);
`default_nettype wire

// ===== dv/emx_core_tb.sv
// emx_core_tb.sv: register and move sequences against emx_core
// assumes: 4k on-chip ram, external memory model on the pins
`timescale 1ns/1ps
`default_nettype none
module emx_core_tb
  import emx_pkg::*;
;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, done, son, sfi, stb, rdn, wrn;
  logic hi, ext, ale, cl, clm;
  logic [7:0] adr = 0, wd = 0, d, srd, rdat, pin;
  logic [15:0] ea;
  emx_req_s rq = '0;
  emx_pins_s pins;
  int num_errors = 0, checks_done = 0;
  always #10 clk = ~clk;
  emx_core DUT (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(1'b1), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_addr(adr), .i_sfr_wdata(wd), .i_req(rq), .i_ad_pin(pin),
    .o_sfr_rdata(srd), .o_done(done), .o_rdata(rdat), .o_sel_onchip(son),
    .o_sel_fifo(sfi), .o_eff_addr(ea), .o_pins(pins), .o_latch_strobe(stb),
    .o_rd_n(rdn), .o_wr_n(wrn), .o_bus_claim(clm));
  emx_mem_model u_mem (.i_clk(clk), .i_pins(pins), .i_stb(stb), .i_rd_n(rdn),
    .i_wr_n(wrn), .o_ad(pin));
  task give_verdict;
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task sw(input logic [7:0] a, v);
    @(negedge clk) {adr, wd, wr} = {a, v, 1'b1};
    @(negedge clk) wr = 0;
  endtask
  task sr(input logic [7:0] a);
    @(negedge clk) {adr, rd} = {a, 1'b1};
    @(negedge clk) rd = 0;
    d = srd;
  endtask
  // one move; flags collect what the pins did until done
  task mv(input logic w, wide, input logic [15:0] p, input logic [7:0] x, v);
    int n;
    @(negedge clk) rq = '{1'b1, w, wide, p, x, v};
    @(negedge clk) rq.start = 0;
    {hi, ext, ale, cl, n} = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk) #1;
      ext |= !rdn || !wrn;
      hi |= pins.ahi_oe[0] && (!rdn || !wrn);
      ale |= stb;
      cl |= clm;
      n++;
    end
    chk("done", n < 60, 1);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1;
    sr(8'h85); chk("cfg", d, 8'h03);
    sr(8'hAA); chk("page", d, 8'h00);
    sw(8'h85, 8'hFF); sr(8'h85); chk("cfgmask", d, 8'h5F);
    for (logic [7:0] k = 0; k < 4; k++) begin
      sw(8'h85, 8'h0C | k);
      mv(1, 0, 0, 8'h30 + k, 8'hA0 + k);
      mv(0, 0, 0, 8'h30 + k, 0);
      chk("rdat", rdat, 8'hA0 + k);
      chk("ahi", hi, 0);
      chk("ale", ale, 1);
      chk("claim", cl, 1);
    end
    sw(8'hAA, 8'h12);
    sw(8'h85, 8'h08); mv(0, 0, 0, 8'h34, 0);
    chk("ea", ea, 16'h1234);
    chk("ahi", hi, 1);
    sw(8'h85, 8'h00); mv(0, 1, 16'h1234, 0, 0);
    chk("ea", ea, 16'h0234);
    chk("on", son, 1);
    chk("ext", ext, 0);
    chk("claim", cl, 0);
    sw(8'h85, 8'h04); mv(0, 1, 16'h2000, 0, 0);
    chk("ahi", hi, 1);
    mv(0, 0, 0, 8'h10, 0);
    chk("ahi", hi, 0);
    chk("ext", ext, 1);
    mv(0, 1, 16'h0FFF, 0, 0);
    chk("on", son, 1);
    sw(8'h85, 8'h4C); mv(0, 1, 16'h0500, 0, 0);
    chk("fifo", sfi, 1);
    chk("ext", ext, 0);
    sw(8'h85, 8'h0C); mv(0, 1, 16'h0500, 0, 0);
    chk("fifo", sfi, 0);
    chk("ext", ext, 1);
    sw(8'h85, 8'h1F); mv(1, 1, 16'h0055, 0, 8'h5A);
    chk("ale", ale, 0);
    mv(0, 1, 16'h0055, 0, 0);
    chk("rdat", rdat, 8'h5A);
    give_verdict;
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== dv/emx_mem_model.sv
// emx_mem_model.sv: off-chip byte memory behind a transparent address latch
// assumes: strobes and pin struct come straight from emx_core
`timescale 1ns/1ps
`default_nettype none
module emx_mem_model
  import emx_pkg::*;
(
  input  wire logic      i_clk,
  input  wire emx_pins_s i_pins,
  input  wire logic      i_stb,
  input  wire logic      i_rd_n,
  input  wire logic      i_wr_n,
  output logic [7:0]     o_ad
);
  logic [7:0] mem [256];
  logic [7:0] lat;
  logic [7:0] last = 8'h00;
  wire  [7:0] a = i_pins.alo_oe[0] ? i_pins.alo_o : lat;
  always_latch if (i_stb) lat <= i_pins.ad_o;
  always @(posedge i_clk) if (!i_wr_n) mem[a] <= i_pins.ad_o;
  always @(posedge i_clk) if (!i_rd_n) last <= mem[a];
  // released pins show the inverse so stale data never looks valid
  assign o_ad = !i_rd_n ? mem[a] : ~last;
endmodule
`default_nettype wire

// ===== include/emx_pkg.sv
// emx_pkg.sv: types for the external memory map and mux control block
// assumes: constants come from emx_regs.svh
package emx_pkg;
  typedef enum logic [1:0] {
    EMX_MAP_INT   = 2'h0,
    EMX_MAP_SPLIT = 2'h1,
    EMX_MAP_BANK  = 2'h2,
    EMX_MAP_EXT   = 2'h3
  } emx_map_e;

  typedef struct packed {
    logic       start;
    logic       wr;
    logic       wide;
    logic [15:0] ptr;
    logic [7:0] idx;
    logic [7:0] wdata;
  } emx_req_s;

  typedef struct packed {
    logic [7:0] ad_o;
    logic [7:0] ad_oe;
    logic [7:0] ahi_o;
    logic [7:0] ahi_oe;
    logic [7:0] alo_o;
    logic [7:0] alo_oe;
  } emx_pins_s;
endpackage

// ===== include/emx_regs.svh
// emx_regs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the core; defines only
`ifndef EMX_REGS_SVH
`define EMX_REGS_SVH
`define EMX_CFG_ADDR      8'h85
`define EMX_PAGE_ADDR     8'hAA
`define EMX_CFG_FAE_BIT   6
`define EMX_CFG_MUX_BIT   4
`define EMX_CFG_MAP_LSB   2
`define EMX_CFG_ALE_LSB   0
`define EMX_CFG_WMASK     8'h5F
`define EMX_CFG_RESET     8'h03
`define EMX_PAGE_RESET    8'h00
`define EMX_FIFO_LO       16'h0400
`define EMX_FIFO_HI       16'h07FF
// read/write strobe is held four cycles so the three-stage pin sampler settles inside it
`define EMX_RD_WR_CYC     3'h4
`define EMX_IRAM_4K_MASK  16'h0FFF
`define EMX_IRAM_2K_MASK  16'h07FF
`endif
